// ===== jlpo_defines.vh
// register offsets, field positions, reset values and defaults for the
// upper-lane link parameter override bank; include once per design file
`ifndef JLPO_DEFINES_VH
`define JLPO_DEFINES_VH

// ********************************
// register indices (byte address = 4 x index)
// ********************************
`define JLPO_IDX_MF_PRESET      8'h78
`define JLPO_IDX_OVR_EN         8'h86
`define JLPO_IDX_SUM56          8'h87
`define JLPO_IDX_SUM78          8'h88
`define JLPO_IDX_IDENT56        8'h89
`define JLPO_IDX_IDENT78        8'h8A

// ********************************
// field positions
// ********************************
`define JLPO_MF_APPLY_BIT       15
`define JLPO_MF_VALUE_HI        14
`define JLPO_MF_VALUE_LO        10
`define JLPO_L5_IDENT_EN_BIT    15
`define JLPO_L6_IDENT_EN_BIT    14
`define JLPO_L7_IDENT_EN_BIT    13
`define JLPO_L8_IDENT_EN_BIT    12
`define JLPO_L5_SUM_EN_BIT      11
`define JLPO_L6_SUM_EN_BIT      10
`define JLPO_L7_SUM_EN_BIT      9
`define JLPO_L8_SUM_EN_BIT      8

// ********************************
// reset values and lane defaults
// ********************************
`define JLPO_REG_RESET          16'h0000
`define JLPO_L5_DEF_IDENT       5'h05
`define JLPO_L6_DEF_IDENT       5'h06
`define JLPO_L7_DEF_IDENT       5'h07
`define JLPO_L8_DEF_IDENT       5'h08
`define JLPO_MF_DEF_INIT        5'h00

// ********************************
// register bus answer
// ********************************
`define JLPO_WAIT_CYCLES        1

`endif

// ===== jlpo_regs.v
// upper-lane link parameter override register bank with APB slave
// assumes one 125 MHz clock, APB master in the same domain, and a lane
// framer that consumes the selected identifiers and checksums
//
// Behaviour
// - apply bit clear: counter runs default; set: counter loads the preset
// - five-bit preset field is the counter start value
// - lane 5 ident default 00101, else ident register 5/6 bits 12-8
// - lane 6 ident default 00110, else ident register 5/6 bits 4-0
// - lane 7 ident default 00111, else ident register 7/8 bits 12-8
// - lane 8 ident default 01000, else ident register 7/8 bits 4-0
// - lane 5 sum computed, or forced from checksum register 5/6 upper byte
// - lanes 6-8 sum computed, or forced from the matching software byte
// - checksum register 5/6: lane 5 upper byte, lane 6 lower byte
// - checksum register 7/8: lane 7 upper byte, lane 8 lower byte
// - ident register 5/6: lane 5 in bits 12-8, lane 6 in 4-0
// - every field read/write, zero after reset
// - ident register 7/8: lane 7 in bits 12-8, lane 8 in 4-0
`timescale 1ns/100ps
`include "jlpo_defines.vh"

module jlpo_regs #(
	parameter ADDR_W = 12
) (
	// clock, enable, reset
	input  wire              clk,
	input  wire              clk_en,
	input  wire              resetn,
	// apb slave
	input  wire [ADDR_W-1:0] paddr,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// write select from the serial link control register
	input  wire              serial_link_write_select,
	// multiframe counter control
	output reg               multiframe_preset_apply,
	output reg  [4:0]        multiframe_preset_value,
	// device-computed checksums
	input  wire [7:0]        lane5_calc_sum,
	input  wire [7:0]        lane6_calc_sum,
	input  wire [7:0]        lane7_calc_sum,
	input  wire [7:0]        lane8_calc_sum,
	// selected alignment configuration fields
	output reg  [4:0]        lane5_ident,
	output reg  [4:0]        lane6_ident,
	output reg  [4:0]        lane7_ident,
	output reg  [4:0]        lane8_ident,
	output reg  [7:0]        lane5_sum,
	output reg  [7:0]        lane6_sum,
	output reg  [7:0]        lane7_sum,
	output reg  [7:0]        lane8_sum,
	// write select as seen by the lanes, registered one cycle late
	output reg               override_valid
);

	// ********************************
	// reset release
	// ********************************
	reg  rst_meta_ff;
	reg  rst_sync_ff;
	wire rst_n = rst_sync_ff;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ********************************
	// helpers
	// ********************************
	function [15:0] merge_lanes;
		input [15:0] old_val;
		input [31:0] wdata;
		input [3:0]  strb;
		begin
			merge_lanes[7:0]  = strb[0] ? wdata[7:0]  : old_val[7:0];
			merge_lanes[15:8] = strb[1] ? wdata[15:8] : old_val[15:8];
		end
	endfunction

	function [4:0] pick_ident;
		input       en;
		input [4:0] forced;
		input [4:0] dflt;
		begin
			pick_ident = en ? forced : dflt;
		end
	endfunction

	function [7:0] pick_sum;
		input       en;
		input [7:0] forced;
		input [7:0] calc;
		begin
			pick_sum = en ? forced : calc;
		end
	endfunction

	// ********************************
	// register storage
	// ********************************
	reg [15:0] mf_preset_ff;
	reg [15:0] ovr_en_ff;
	reg [15:0] sum56_ff;
	reg [15:0] sum78_ff;
	reg [15:0] ident56_ff;
	reg [15:0] ident78_ff;

	// word index; low two address bits are the byte within the word
	wire [ADDR_W-3:0] widx     = paddr[ADDR_W-1:2];
	wire              hit_mf   = (widx == `JLPO_IDX_MF_PRESET);
	wire              hit_en   = (widx == `JLPO_IDX_OVR_EN);
	wire              hit_s56  = (widx == `JLPO_IDX_SUM56);
	wire              hit_s78  = (widx == `JLPO_IDX_SUM78);
	wire              hit_i56  = (widx == `JLPO_IDX_IDENT56);
	wire              hit_i78  = (widx == `JLPO_IDX_IDENT78);
	wire              hit_any  = hit_mf | hit_en | hit_s56 | hit_s78 | hit_i56 | hit_i78;
	// one wait state: answer in the second access cycle
	wire              acc      = psel & penable & ~pready;
	wire              wr_done  = acc & pwrite & hit_any;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mf_preset_ff <= `JLPO_REG_RESET;
			ovr_en_ff    <= `JLPO_REG_RESET;
			sum56_ff     <= `JLPO_REG_RESET;
			sum78_ff     <= `JLPO_REG_RESET;
			ident56_ff   <= `JLPO_REG_RESET;
			ident78_ff   <= `JLPO_REG_RESET;
		end else if (clk_en && wr_done) begin
			// reserved bits are stored as written so reads echo them back
			if (hit_mf)
				mf_preset_ff <= merge_lanes(mf_preset_ff, pwdata, pstrb);
			if (hit_en)
				ovr_en_ff <= merge_lanes(ovr_en_ff, pwdata, pstrb);
			if (hit_s56)
				sum56_ff <= merge_lanes(sum56_ff, pwdata, pstrb);
			if (hit_s78)
				sum78_ff <= merge_lanes(sum78_ff, pwdata, pstrb);
			if (hit_i56)
				ident56_ff <= merge_lanes(ident56_ff, pwdata, pstrb);
			if (hit_i78)
				ident78_ff <= merge_lanes(ident78_ff, pwdata, pstrb);
		end
	end

	// ********************************
	// bus answer
	// ********************************
	reg [15:0] rd_word;

	always @* begin
		rd_word = 16'h0000;
		case (1'b1)
			hit_mf:  rd_word = mf_preset_ff;
			hit_en:  rd_word = ovr_en_ff;
			hit_s56: rd_word = sum56_ff;
			hit_s78: rd_word = sum78_ff;
			hit_i56: rd_word = ident56_ff;
			hit_i78: rd_word = ident78_ff;
			default: rd_word = 16'h0000;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= acc;
			pslverr <= acc & ~hit_any;
			prdata  <= (acc && !pwrite) ? {16'h0000, rd_word} : 32'h00000000;
		end
	end

	// ********************************
	// lane field selection
	// ********************************
	// the enables only act while the write select is high; otherwise all
	// lanes fall back to default idents and computed sums rather than half-written overrides
	wire en_ok = serial_link_write_select;
	wire id5_en = en_ok & ovr_en_ff[`JLPO_L5_IDENT_EN_BIT];
	wire id6_en = en_ok & ovr_en_ff[`JLPO_L6_IDENT_EN_BIT];
	wire id7_en = en_ok & ovr_en_ff[`JLPO_L7_IDENT_EN_BIT];
	wire id8_en = en_ok & ovr_en_ff[`JLPO_L8_IDENT_EN_BIT];
	wire s5_en  = en_ok & ovr_en_ff[`JLPO_L5_SUM_EN_BIT];
	wire s6_en  = en_ok & ovr_en_ff[`JLPO_L6_SUM_EN_BIT];
	wire s7_en  = en_ok & ovr_en_ff[`JLPO_L7_SUM_EN_BIT];
	wire s8_en  = en_ok & ovr_en_ff[`JLPO_L8_SUM_EN_BIT];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			multiframe_preset_apply <= 1'b0;
			multiframe_preset_value <= `JLPO_MF_DEF_INIT;
			lane5_ident             <= `JLPO_L5_DEF_IDENT;
			lane6_ident             <= `JLPO_L6_DEF_IDENT;
			lane7_ident             <= `JLPO_L7_DEF_IDENT;
			lane8_ident             <= `JLPO_L8_DEF_IDENT;
			lane5_sum               <= 8'h00;
			lane6_sum               <= 8'h00;
			lane7_sum               <= 8'h00;
			lane8_sum               <= 8'h00;
			override_valid          <= 1'b0;
		end else if (clk_en) begin
			multiframe_preset_apply <= mf_preset_ff[`JLPO_MF_APPLY_BIT];
			// default start value unless the preset is applied
			multiframe_preset_value <= mf_preset_ff[`JLPO_MF_APPLY_BIT]
				? mf_preset_ff[`JLPO_MF_VALUE_HI:`JLPO_MF_VALUE_LO]
				: `JLPO_MF_DEF_INIT;
			lane5_ident <= pick_ident(id5_en, ident56_ff[12:8], `JLPO_L5_DEF_IDENT);
			lane6_ident <= pick_ident(id6_en, ident56_ff[4:0], `JLPO_L6_DEF_IDENT);
			lane7_ident <= pick_ident(id7_en, ident78_ff[12:8], `JLPO_L7_DEF_IDENT);
			lane8_ident <= pick_ident(id8_en, ident78_ff[4:0], `JLPO_L8_DEF_IDENT);
			lane5_sum   <= pick_sum(s5_en, sum56_ff[15:8], lane5_calc_sum);
			lane6_sum   <= pick_sum(s6_en, sum56_ff[7:0], lane6_calc_sum);
			lane7_sum   <= pick_sum(s7_en, sum78_ff[15:8], lane7_calc_sum);
			lane8_sum   <= pick_sum(s8_en, sum78_ff[7:0], lane8_calc_sum);
			// outputs above feed the alignment configuration data directly
			override_valid <= en_ok;
		end
	end

endmodule

// ===== jlpo_regs_props.sv
// port-level assertions for the upper-lane override bank
// assumes a bind onto jlpo_regs, one clock, clk_en held high
`timescale 1ns/100ps
module jlpo_regs_chk #(
	parameter ADDR_W = 12
) (
	// bus side
	input wire              clk,
	input wire              resetn,
	input wire [ADDR_W-1:0] paddr,
	input wire              psel,
	input wire              penable,
	input wire              pready,
	input wire              pslverr,
	input wire [31:0]       prdata,
	// lane side
	input wire              serial_link_write_select,
	input wire              multiframe_preset_apply,
	input wire [4:0]        multiframe_preset_value,
	input wire [4:0]        lane5_ident,
	input wire [4:0]        lane8_ident,
	input wire [7:0]        lane5_sum,
	input wire [7:0]        lane5_calc_sum
);
	wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
	wire              mapped = idx == 10'h78 || (idx >= 10'h86 && idx <= 10'h8A);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready stuck");
	chk_ready_due: assert property (psel && penable && !pready |=> pready)
		else $error("no answer");
	chk_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("stray ready");
	chk_error_map: assert property (pready |-> pslverr == !mapped)
		else $error("error flag wrong");
	chk_rdata_quiet: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data idle");
	// three low cycles cover either gating latency
	chk_ident_default: assert property ((!serial_link_write_select)[*3] |=>
		lane5_ident == 5'h05 && lane8_ident == 5'h08) else $error("ident default");
	// lane flops leave reset two edges after resetn rises
	chk_sum_computed: assert property ((!serial_link_write_select && $past(resetn, 2))[*3] |=>
		lane5_sum == $past(lane5_calc_sum)) else $error("sum not computed");
	chk_preset_idle: assert property (!multiframe_preset_apply |->
		multiframe_preset_value == 5'h00) else $error("preset leaks");
endmodule

bind jlpo_regs jlpo_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== jlpo_lane_model.sv
// stand-in for the checksum logic feeding the bank
// assumes fixed sums so computed and forced values differ
`timescale 1ns/100ps
module jlpo_lane_model (
	// computed sums
	output logic [7:0] lane5_calc_sum,
	output logic [7:0] lane6_calc_sum,
	output logic [7:0] lane7_calc_sum,
	output logic [7:0] lane8_calc_sum
);
	assign lane5_calc_sum = 8'h51;
	assign lane6_calc_sum = 8'h52;
	assign lane7_calc_sum = 8'h53;
	assign lane8_calc_sum = 8'h54;
endmodule

// ===== tb_jlpo_regs.sv
// self-checking bench for the override bank
// assumes jlpo_regs, its checker and the lane model alongside
`timescale 1ns/100ps
module tb_jlpo_regs;
	logic        clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
	logic [3:0]  pstrb = 4'hF;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic        serial_link_write_select = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, override_valid, multiframe_preset_apply, er;
	logic [4:0]  multiframe_preset_value, lane5_ident, lane6_ident, lane7_ident, lane8_ident;
	logic [7:0]  lane5_calc_sum, lane6_calc_sum, lane7_calc_sum, lane8_calc_sum;
	logic [7:0]  lane5_sum, lane6_sum, lane7_sum, lane8_sum;
	logic [11:0] regs [6] = '{12'h1E0, 12'h218, 12'h21C, 12'h220, 12'h224, 12'h228};
	// reserved bits of every register left at zero
	logic [31:0] rw_data [6] = '{32'hA400, 32'hFF00, 32'hA5C3, 32'hA5C3, 32'h0503, 32'h0503};
	int          errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	jlpo_regs DUT (.*);
	jlpo_lane_model PEER (.*);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000)
			tally_and_finish(1);
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		// pready ends this wait; if it never rises, only the bench timeout does
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task t_reset;
		foreach (regs[i]) begin
			apb(regs[i], 1'b0, 32'h0);
			chk("reset value", 32'h0, rd);
		end
		chk("lane6 ident", 5'h06, lane6_ident);
		chk("lane7 ident", 5'h07, lane7_ident);
		$display("test reset done");
	endtask
	task t_rw;
		foreach (regs[i]) begin
			apb(regs[i], 1'b1, rw_data[i]);
			apb(regs[i], 1'b0, 32'h0);
			chk("readback", rw_data[i], rd);
		end
		chk("preset apply", 1'b1, multiframe_preset_apply);
		chk("preset value", 5'h09, multiframe_preset_value);
		apb(12'h1E0, 1'b1, 32'h00007C00);
		repeat (2) @(posedge clk);
		chk("preset idle", 5'h00, multiframe_preset_value);
		apb(12'h200, 1'b1, 32'h1);
		chk("unmapped", 1'b1, er);
		$display("test rw done");
	endtask
	task t_ident;
		serial_link_write_select <= 1'b1;
		apb(12'h224, 1'b1, 32'h00000A15);
		apb(12'h228, 1'b1, 32'h00001C03);
		apb(12'h21C, 1'b1, 32'h0000A55A);
		apb(12'h220, 1'b1, 32'h00003CC3);
		apb(12'h218, 1'b1, 32'h0000FF00);
		repeat (2) @(posedge clk);
		chk("lane5 ident", 5'h0A, lane5_ident);
		chk("lane6 ident", 5'h15, lane6_ident);
		chk("lane7 ident", 5'h1C, lane7_ident);
		chk("lane8 ident", 5'h03, lane8_ident);
		chk("lane5 sum", 8'hA5, lane5_sum);
		chk("lane6 sum", 8'h5A, lane6_sum);
		chk("lane7 sum", 8'h3C, lane7_sum);
		chk("lane8 sum", 8'hC3, lane8_sum);
		chk("override valid", 1'b1, override_valid);
		serial_link_write_select <= 1'b0;
		repeat (3) @(posedge clk);
		chk("override invalid", 1'b0, override_valid);
		chk("lane8 ident off", 5'h08, lane8_ident);
		chk("lane7 sum off", 8'h53, lane7_sum);
		$display("test ident done");
	endtask
	task tally_and_finish(input int extra);
		errors += extra;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_rw();
		t_ident();
		tally_and_finish(0);
	end
endmodule
